// ===== design/clm_interval.sv
// Reporting interval timer: one boundary pulse per programmed interval.
// Assumes interval_s is 0 (off) or within the accepted range.
`timescale 1ns/1ns
`include "clm_params.svh"
module clm_interval #(
   parameter int unsigned CYC_PER_SEC = `CLM_SEC_MS * `CLM_CLK_KHZ
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Timer link.
   clm_tmr_if.tmr tmr
);

   typedef struct packed {
      logic [27:0] pre;
      logic [5:0] sec;
      logic bnd;
   } clm_tmr_s;

   localparam logic [27:0] PRE_LAST = 28'(CYC_PER_SEC - 1);

   clm_tmr_s st_ff;
   clm_tmr_s nxt_st;

   // Seconds prescaler and interval counter; zero interval stops both.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.bnd = 1'b0;
      if (tmr.restart || tmr.interval_s == 6'h00) begin
         nxt_st.pre = 28'h000_0000;
         nxt_st.sec = 6'h00;
      end else if (st_ff.pre == PRE_LAST) begin
         nxt_st.pre = 28'h000_0000;
         if (st_ff.sec == tmr.interval_s - 6'h01) begin
            nxt_st.sec = 6'h00;
            nxt_st.bnd = 1'b1;
         end else begin
            nxt_st.sec = st_ff.sec + 6'h01;
         end
      end else begin
         nxt_st.pre = st_ff.pre + 28'h000_0001;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tmr.boundary = st_ff.bnd;

endmodule : clm_interval

// ===== design/clm_lead_mon.sv
// Low-speed serial card port logic with control lead change monitor.
// Assumes an Avalon-MM master on clk_sys and asynchronous port pins.
//
// What this block does
// - Up to eight ports, own role and rate.
// - Port rates never exceed 19.2 kbps.
// - Asynchronous data over-sampled at programmable rate.
// - Normal or looped transmit clocking per port.
// - Fast mode puts RTS/CTS in bit eight.
// - Fast mode only at 19.2 kbps or below.
// - Report lead changes every 5 to 55 seconds.
// - No event for a port without change.
// - Interval zero: changes shown only when polled.
// - Current lead state readable at any time.
// - One monitored lead type for the node.
// - Monitorable leads: RTS, DSR, DCD, CTS, DTR.
// - Per-port lead state bitmap readable by host.
`timescale 1ns/1ns
`include "clm_params.svh"
module clm_lead_mon #(
   parameter int NPORT = 8,
   parameter int unsigned CYC_PER_SEC = `CLM_SEC_MS * `CLM_CLK_KHZ
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM register slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Port pins: five leads per port, receive data, external clock.
   input wire logic [NPORT*5-1:0] lead_pin,
   input wire logic [NPORT-1:0] rx_pin,
   input wire logic [NPORT-1:0] ext_clk_pin,
   // Customer data from the transmit path, one byte per port.
   input wire logic [NPORT*8-1:0] cust_data,
   input wire logic [NPORT-1:0] cust_valid,
   // Bytes towards the cell path, with lead bit in fast mode.
   output logic [NPORT*8-1:0] pkt_data,
   output logic [NPORT-1:0] pkt_valid,
   // Over-sampled receive data and transmit clocks.
   output logic [NPORT-1:0] rx_bit,
   output logic [NPORT-1:0] tx_clk_out,
   // Interrupt.
   output logic irq
);

   localparam logic [27:0] BAUD_MOD = 28'(`CLM_CLK_KHZ * `CLM_HZ_PER_KHZ);
   localparam int SW = 10;

   typedef struct packed {
      clm_pkg::clm_bus_e bus;
      logic wreq;
      logic [31:0] rdata;
      logic irq;
      logic [3:0] idx;
      logic [5:0] ivl;
      logic tmr_rst;
      logic [NPORT-1:0] fast;
      logic [NPORT-1:0] dte;
      logic [NPORT-1:0] loop;
      logic [15:0] ovs;
      logic [15:0] ovs_cnt;
      logic [NPORT-1:0][7:0] rate;
      logic [SW-1:0] stat;
      logic [SW-1:0] mask;
      logic [NPORT-1:0] prev;
      logic [NPORT-1:0] rxs;
      logic [NPORT-1:0][27:0] acc;
      logic [NPORT-1:0] bclk;
      logic [NPORT-1:0] txc;
      logic [NPORT-1:0][7:0] pkt;
      logic [NPORT-1:0] pv;
   } clm_top_s;

   clm_top_s st_ff;
   clm_top_s nxt_st;

   logic [NPORT*5-1:0] lead_lvl;
   logic [NPORT-1:0] rx_lvl;
   logic [NPORT-1:0] ext_lvl;
   clm_tmr_if tmr_link ();

   // Maps the node lead index and a port role to one lead bit.
   function automatic clm_pkg::clm_sel_s lead_sel(input logic [3:0] idx,
                                                  input logic dte);
      clm_pkg::clm_sel_s s;
      s.valid = 1'b0;
      s.pos = 3'h0;
      if (idx == 4'h3) begin
         s.valid = 1'b1;
         s.pos = dte ? 3'(`CLM_LEAD_DSR) : 3'(`CLM_LEAD_DTR);
      end else if (idx == 4'h4) begin
         s.valid = 1'b1;
         s.pos = dte ? 3'(`CLM_LEAD_CTS) : 3'(`CLM_LEAD_RTS);
      end else if (idx == 4'h7 && dte) begin
         s.valid = 1'b1;
         s.pos = 3'(`CLM_LEAD_DCD);
      end
      return s;
   endfunction : lead_sel

   // Merges write data into a register under the byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // Synchronisers for every lead, data and clock pin.
   clm_sampler #(.W(NPORT*5)) u_lead_smp (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin(lead_pin),
      .level(lead_lvl)
   );

   clm_sampler #(.W(2*NPORT)) u_line_smp (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin({ext_clk_pin, rx_pin}),
      .level({ext_lvl, rx_lvl})
   );

   // Reporting interval timer.
   clm_interval #(.CYC_PER_SEC(CYC_PER_SEC)) u_interval (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tmr(tmr_link.tmr)
   );

   assign tmr_link.interval_s = st_ff.ivl;
   assign tmr_link.restart = st_ff.tmr_rst;

   // Next state of the whole block.
   always_comb begin
      logic done;
      logic [NPORT-1:0] cur;
      logic [NPORT-1:0] sel_ok;
      logic [NPORT-1:0] chg;
      logic [SW-1:0] set;
      logic [SW-1:0] clr;
      logic [31:0] rd;
      logic [31:0] wv;
      logic [27:0] sum;
      logic [7:0] nrate;
      clm_pkg::clm_sel_s sel;
      done = 1'b0;
      cur = '0;
      sel_ok = '0;
      chg = '0;
      set = '0;
      clr = '0;
      rd = 32'h0000_0000;
      wv = 32'h0000_0000;
      sum = 28'h000_0000;
      nrate = 8'h00;
      sel = '0;
      nxt_st = st_ff;
      nxt_st.tmr_rst = 1'b0;

      // One node-wide lead type, resolved per port role.
      for (int p = 0; p < NPORT; p++) begin
         sel = lead_sel(st_ff.idx, st_ff.dte[p]);
         sel_ok[p] = sel.valid;
         cur[p] = sel.valid & lead_lvl[p*5 + int'(sel.pos)];
      end

      // Register read decode.
      if (avs_address == `CLM_OFF_CTRL) begin
         rd[`CLM_CTRL_IDX_LSB +: 4] = st_ff.idx;
         rd[`CLM_CTRL_IVL_LSB +: 6] = st_ff.ivl;
         rd[`CLM_CTRL_FAST_LSB +: NPORT] = st_ff.fast;
      end else if (avs_address == `CLM_OFF_ROLE) begin
         rd[`CLM_ROLE_DTE_LSB +: NPORT] = st_ff.dte;
         rd[`CLM_ROLE_LOOP_LSB +: NPORT] = st_ff.loop;
      end else if (avs_address == `CLM_OFF_OVS) begin
         rd[15:0] = st_ff.ovs;
      end else if (avs_address == `CLM_OFF_STAT) begin
         rd[SW-1:0] = st_ff.stat;
      end else if (avs_address == `CLM_OFF_MASK) begin
         rd[SW-1:0] = st_ff.mask;
      end else if (avs_address == `CLM_OFF_POLL) begin
         rd[NPORT-1:0] = (cur ^ st_ff.prev) & sel_ok;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            if (avs_address == `CLM_OFF_RATE + 8'(4*p)) begin
               rd[7:0] = st_ff.rate[p];
            end else if (avs_address == `CLM_OFF_LEAD + 8'(4*p)) begin
               rd[4:0] = lead_lvl[p*5 +: 5];
               rd[8] = st_ff.prev[p];
               rd[9] = st_ff.dte[p];
               rd[10] = st_ff.fast[p];
            end
         end
      end

      // Bus answer: one wait cycle, then waitrequest low for one edge.
      case (st_ff.bus)
         clm_pkg::CLM_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               nxt_st.bus = clm_pkg::CLM_BUS_DONE;
               nxt_st.wreq = 1'b0;
               nxt_st.rdata = avs_read ? rd : 32'h0000_0000;
            end
         end
         clm_pkg::CLM_BUS_DONE: begin
            done = 1'b1;
            nxt_st.bus = clm_pkg::CLM_BUS_IDLE;
            nxt_st.wreq = 1'b1;
         end
         default: begin
            nxt_st.bus = clm_pkg::CLM_BUS_IDLE;
            nxt_st.wreq = 1'b1;
         end
      endcase

      // Register writes take effect at the completing edge.
      if (done && avs_write) begin
         if (avs_address == `CLM_OFF_CTRL) begin
            wv = be_merge({8'h00, st_ff.fast, 2'b00, st_ff.ivl, 4'h0,
                           st_ff.idx}, avs_writedata, avs_byteenable);
            if (wv[`CLM_CTRL_IDX_LSB +: 4] <= `CLM_IDX_MAX) begin
               nxt_st.idx = wv[`CLM_CTRL_IDX_LSB +: 4];
            end else begin
               set[`CLM_STAT_ERR] = 1'b1;
            end
            if (wv[`CLM_CTRL_IVL_LSB +: 6] == 6'h00
                || (wv[`CLM_CTRL_IVL_LSB +: 6] >= `CLM_IVL_MIN
                    && wv[`CLM_CTRL_IVL_LSB +: 6] <= `CLM_IVL_MAX)) begin
               nxt_st.ivl = wv[`CLM_CTRL_IVL_LSB +: 6];
            end else begin
               set[`CLM_STAT_ERR] = 1'b1;
            end
            nxt_st.fast = wv[`CLM_CTRL_FAST_LSB +: NPORT];
            nxt_st.tmr_rst = 1'b1;
         end else if (avs_address == `CLM_OFF_ROLE) begin
            wv = be_merge({16'h0000, st_ff.loop, st_ff.dte}, avs_writedata,
                          avs_byteenable);
            nxt_st.dte = wv[`CLM_ROLE_DTE_LSB +: NPORT];
            nxt_st.loop = wv[`CLM_ROLE_LOOP_LSB +: NPORT];
         end else if (avs_address == `CLM_OFF_OVS) begin
            wv = be_merge({16'h0000, st_ff.ovs}, avs_writedata,
                          avs_byteenable);
            nxt_st.ovs = wv[15:0];
         end else if (avs_address == `CLM_OFF_STAT) begin
            clr = avs_byteenable[0] ? avs_writedata[SW-1:0] : '0;
            clr[SW-1:8] = avs_byteenable[1] ? avs_writedata[SW-1:8] : '0;
         end else if (avs_address == `CLM_OFF_MASK) begin
            wv = be_merge({22'h00_0000, st_ff.mask}, avs_writedata,
                          avs_byteenable);
            nxt_st.mask = wv[SW-1:0];
         end else begin
            for (int p = 0; p < NPORT; p++) begin
               if (avs_address == `CLM_OFF_RATE + 8'(4*p)
                   && avs_byteenable[0]) begin
                  nrate = avs_writedata[7:0];
                  if (nrate <= `CLM_RATE_MAX
                      && avs_writedata[31:8] == 24'h00_0000) begin
                     nxt_st.rate[p] = nrate;
                  end else begin
                     set[`CLM_STAT_ERR] = 1'b1;
                  end
               end
            end
         end
      end

      // A completed poll read hands the shown changes over as reported.
      if (done && avs_read && avs_address == `CLM_OFF_POLL) begin
         nxt_st.prev = st_ff.prev ^ st_ff.rdata[NPORT-1:0];
      end

      // Interval boundary: latch lead, compare, flag mismatches and the boundary bit.
      if (tmr_link.boundary) begin
         chg = (cur ^ st_ff.prev) & sel_ok;
         nxt_st.prev = cur;
         set[NPORT-1:0] = chg;
         set[`CLM_STAT_BND] = 1'b1;
      end

      // Sticky status: a set in the clearing cycle wins.
      nxt_st.stat = (st_ff.stat & ~clr) | set;
      nxt_st.irq = |(nxt_st.stat & nxt_st.mask);

      // Over-sampling tick for asynchronous receive data.
      if (st_ff.ovs_cnt + 16'h0001 >= st_ff.ovs) begin
         nxt_st.ovs_cnt = 16'h0000;
         nxt_st.rxs = rx_lvl;
      end else begin
         nxt_st.ovs_cnt = st_ff.ovs_cnt + 16'h0001;
      end

      // Per-port baud generator, clock selection and fast lead bit.
      for (int p = 0; p < NPORT; p++) begin
         sum = st_ff.acc[p] + 28'(st_ff.rate[p]) * `CLM_BAUD_STEP;
         if (sum >= BAUD_MOD) begin
            nxt_st.acc[p] = sum - BAUD_MOD;
            nxt_st.bclk[p] = ~st_ff.bclk[p];
         end else begin
            nxt_st.acc[p] = sum;
         end
         nxt_st.txc[p] = st_ff.loop[p] ? ext_lvl[p] : st_ff.bclk[p];
         nxt_st.pv[p] = cust_valid[p];
         nxt_st.pkt[p] = cust_data[p*8 +: 8];
         if (st_ff.fast[p] && st_ff.rate[p] != 8'h00
             && st_ff.rate[p] <= `CLM_RATE_MAX) begin
            nxt_st.pkt[p][7] = st_ff.dte[p]
               ? lead_lvl[p*5 + `CLM_LEAD_CTS]
               : lead_lvl[p*5 + `CLM_LEAD_RTS];
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.bus <= clm_pkg::CLM_BUS_IDLE;
         st_ff.wreq <= 1'b1;
         st_ff.idx <= `CLM_RST_IDX;
         st_ff.ivl <= `CLM_RST_IVL;
         st_ff.ovs <= `CLM_RST_OVS;
         st_ff.rate <= {NPORT{`CLM_RST_RATE}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register.
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.wreq;
   assign irq = st_ff.irq;
   assign pkt_data = st_ff.pkt;
   assign pkt_valid = st_ff.pv;
   assign rx_bit = st_ff.rxs;
   assign tx_clk_out = st_ff.txc;

endmodule : clm_lead_mon

// ===== design/clm_params.svh
// Register offsets, field positions, reset values and timing figures of
// the control lead change monitor.
// Assumes a 32-bit register bus with byte addresses on an 8-bit address.
`ifndef CLM_PARAMS_SVH
`define CLM_PARAMS_SVH

// Register byte offsets.
`define CLM_OFF_CTRL 8'h00
`define CLM_OFF_ROLE 8'h04
`define CLM_OFF_OVS 8'h08
`define CLM_OFF_STAT 8'h0C
`define CLM_OFF_MASK 8'h10
`define CLM_OFF_POLL 8'h14
`define CLM_OFF_RATE 8'h20
`define CLM_OFF_LEAD 8'h40

// Field positions inside the control and role registers.
`define CLM_CTRL_IDX_LSB 0
`define CLM_CTRL_IVL_LSB 8
`define CLM_CTRL_FAST_LSB 16
`define CLM_ROLE_DTE_LSB 0
`define CLM_ROLE_LOOP_LSB 8

// Status bit positions above the per-port change bits.
`define CLM_STAT_BND 8
`define CLM_STAT_ERR 9

// Reset values.
`define CLM_RST_IDX 4'h4
`define CLM_RST_IVL 6'h05
`define CLM_RST_OVS 16'h0010
`define CLM_RST_RATE 8'hC0

// Limits: interval in seconds, rate in units of 100 bit/s.
`define CLM_IVL_MIN 6'h05
`define CLM_IVL_MAX 6'h37
`define CLM_RATE_MAX 8'hC0
`define CLM_IDX_MAX 4'hC

// Lead bit positions inside a port's lead vector.
`define CLM_LEAD_RTS 0
`define CLM_LEAD_DSR 1
`define CLM_LEAD_DCD 2
`define CLM_LEAD_CTS 3
`define CLM_LEAD_DTR 4

// Timing: one second in ms, clock rate in kHz, baud generator step.
`define CLM_SEC_MS 32'h0000_03E8
`define CLM_CLK_KHZ 32'h0003_D090
`define CLM_HZ_PER_KHZ 32'h0000_03E8
`define CLM_BAUD_STEP 28'h000_00C8

`endif

// ===== design/clm_pkg.sv
// Types shared by the control lead change monitor modules.
// Assumes the constants of clm_params.svh are included where needed.
package clm_pkg;

   // Register bus answer states, one-hot.
   typedef enum logic [1:0] {
      CLM_BUS_IDLE = 2'b01,
      CLM_BUS_DONE = 2'b10
   } clm_bus_e;

   // Five control leads of one low-speed port.
   typedef logic [4:0] clm_leads_t;

   // Selected lead of one port: valid flag and bit position.
   typedef struct packed {
      logic valid;
      logic [2:0] pos;
   } clm_sel_s;

endpackage : clm_pkg

// ===== design/clm_sampler.sv
// Pin synchroniser with agreement filter, one bit per lane.
// Assumes its inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module clm_sampler #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins in, filtered levels out.
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } clm_smp_s;

   clm_smp_s st_ff;
   clm_smp_s nxt_st;

   // A change counts only once the second and third stages agree.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.q = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3))
         | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
   end

   // State register.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.q;

endmodule : clm_sampler

// ===== design/clm_tmr_if.sv
// Interval timer link between the monitor core and its timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface clm_tmr_if;
   logic [5:0] interval_s;
   logic restart;
   logic boundary;

   modport ctl (output interval_s, output restart, input boundary);
   modport tmr (input interval_s, input restart, output boundary);
endinterface : clm_tmr_if

// ===== dv/clm_lead_mon_properties.sv
// Port-side checks of the lead change monitor.
// Assumes it is bound into clm_lead_mon and sees only its ports.
`timescale 1ns/1ns
module clm_lead_mon_properties #(
   parameter int NPORT = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Register bus.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Data path and interrupt.
   input wire logic [NPORT*8-1:0] cust_data,
   input wire logic [NPORT-1:0] cust_valid,
   input wire logic [NPORT*8-1:0] pkt_data,
   input wire logic [NPORT-1:0] pkt_valid,
   input wire logic irq
);
   // The seven low bits of every byte pass untouched in any mode.
   localparam logic [NPORT*8-1:0] LOW7 = {NPORT{8'h7F}};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_wait_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_wait_cause: assert property (
      !avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_read_hold: assert property (
      avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data moved between accesses");
   a_write_zero: assert property (
      avs_write && !avs_waitrequest |-> avs_readdata == 32'h0000_0000)
      else $error("write answer carries data");
   a_valid_delay: assert property (
      $past(resetn) |-> pkt_valid == $past(cust_valid))
      else $error("byte valid not one cycle late");
   a_low_bits: assert property (
      $past(resetn) |-> (pkt_data & LOW7) == ($past(cust_data) & LOW7))
      else $error("customer bits altered");
   a_irq_clear: assert property (
      $fell(irq) |-> $past(avs_write && !avs_waitrequest))
      else $error("interrupt fell without a write");

   // Main scenarios reached.
   c_read: cover property (avs_read && !avs_waitrequest);
   c_irq: cover property ($rose(irq));
   c_fast: cover property (pkt_valid[0] && pkt_data[7]);
endmodule : clm_lead_mon_properties

bind clm_lead_mon clm_lead_mon_properties #(.NPORT(NPORT)) u_props (
   .clk_sys(clk_sys), .resetn(resetn), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cust_data(cust_data),
   .cust_valid(cust_valid), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
   .irq(irq)
);

// ===== dv/clm_lead_mon_test.sv
// Self-checking bench of the lead change monitor over Avalon-MM.
// Assumes the design files and clm_params.svh are compiled first.
`timescale 1ns/1ns
`include "clm_params.svh"
module clm_lead_mon_test;
   // One second shortened to 20 cycles, so an interval of 5 is 100.
   localparam int NPORT = 8;
   localparam int unsigned CPS = 20;
   localparam int IVL = 5 * CPS;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [39:0] lead_req = 40'h00_0000_0000;
   logic [39:0] lead_pin;
   logic [7:0] rx_pin, ext_clk_pin, pkt_valid, rx_bit, tx_clk_out;
   logic [7:0] cust_valid = 8'h00;
   logic [63:0] cust_data = 64'h0000_0000_0000_0000;
   logic [63:0] pkt_data;
   logic irq;
   logic [31:0] rd;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;

   clm_lead_mon #(.NPORT(NPORT), .CYC_PER_SEC(CPS)) DUT (
      .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .lead_pin(lead_pin), .rx_pin(rx_pin), .ext_clk_pin(ext_clk_pin),
      .cust_data(cust_data), .cust_valid(cust_valid),
      .pkt_data(pkt_data), .pkt_valid(pkt_valid), .rx_bit(rx_bit),
      .tx_clk_out(tx_clk_out), .irq(irq));
   clm_port_model u_port (.clk_sys(clk_sys), .lead_req(lead_req),
      .lead_pin(lead_pin), .rx_pin(rx_pin), .ext_clk_pin(ext_clk_pin));

   // Clock of 4 ns period.
   always #2 clk_sys = ~clk_sys;

   // A hang ends the run as a mismatch.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         mismatches++;
         complete_run();
      end
   end

   // Prints counts and verdict, then stops.
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // Compares a seen value with the expected one.
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One bus access, held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // Register write, and read with masked compare.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rchk(input string what, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd & m, exp);
   endtask : rchk

   // Waits a number of cycles, or samples settled outputs.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic irq_is(input logic e);
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
   endtask : irq_is
   task automatic pkt_is(input logic [15:0] e);
      cyc(10);
      @(negedge clk_sys);
      check("pkt", {16'h0000, pkt_data[15:0]}, {16'h0000, e});
   endtask : pkt_is
   // Sampled data and looped clock must turn with the far side's toggle.
   task automatic line_is;
      logic [7:0] r;
      logic t;
      logic ok;
      @(negedge clk_sys);
      r = rx_bit;
      t = tx_clk_out[0];
      ok = r == 8'h55 || r == 8'hAA;
      cyc(16);
      @(negedge clk_sys);
      check("rx level", {31'h0000_0000, ok}, 32'h0000_0001);
      check("rx turn", {24'h00_0000, rx_bit}, {24'h00_0000, ~r});
      check("txc loop", {31'h0000_0000, tx_clk_out[0]}, {31'h0, ~t});
   endtask : line_is

   // Main sequence of tests.
   initial begin
      logic [31:0] bad [3];
      bad = '{32'h0000_0404, 32'h0000_3804, 32'h0000_050D};
      cyc(10);
      resetn <= 1'b1;
      rchk("ctrl", `CLM_OFF_CTRL, ALL, 32'h0000_0504);
      rchk("ovs", `CLM_OFF_OVS, ALL, 32'h0000_0010);
      for (int p = 0; p < NPORT; p++) begin
         rchk("rate", 8'(`CLM_OFF_RATE + 4 * p), ALL, 32'h0000_00C0);
      end
      rchk("mask", `CLM_OFF_MASK, ALL, 32'h0000_0000);
      rchk("unmapped", 8'h18, ALL, 32'h0000_0000);
      wr(`CLM_OFF_OVS, 32'h0000_0004);
      rchk("ovs set", `CLM_OFF_OVS, ALL, 32'h0000_0004);
      wr(`CLM_OFF_ROLE, 32'h0000_0104);
      rchk("role", `CLM_OFF_ROLE, ALL, 32'h0000_0104);
      line_is();
      lead_req[14:10] <= 5'b10110;
      cyc(10);
      rchk("lead", 8'(`CLM_OFF_LEAD + 8), 32'h0000_021F, 32'h0000_0216);
      $display("test registers done");
      wr(`CLM_OFF_CTRL, 32'h0000_0504);
      wr(`CLM_OFF_STAT, 32'h0000_03FF);
      lead_req[0] <= 1'b1;
      cyc(IVL + 10);
      rchk("stat", `CLM_OFF_STAT, ALL, 32'h0000_0101);
      wr(`CLM_OFF_STAT, 32'h0000_03FF);
      cyc(IVL);
      rchk("stat quiet", `CLM_OFF_STAT, ALL, 32'h0000_0100);
      for (int i = 0; i < 3; i++) begin
         wr(`CLM_OFF_CTRL, bad[i]);
         rchk("ctrl kept", `CLM_OFF_CTRL, ALL, 32'h0000_0504);
      end
      rchk("reject", `CLM_OFF_STAT, 32'h0000_0200, 32'h0000_0200);
      wr(`CLM_OFF_CTRL, 32'h0000_3704);
      rchk("ctrl max", `CLM_OFF_CTRL, ALL, 32'h0000_3704);
      wr(`CLM_OFF_CTRL, 32'h0000_0504);
      $display("test interval done");
      wr(`CLM_OFF_MASK, 32'h0000_0001);
      wr(`CLM_OFF_STAT, 32'h0000_03FF);
      irq_is(1'b0);
      lead_req[0] <= 1'b0;
      cyc(IVL + 10);
      irq_is(1'b1);
      wr(`CLM_OFF_MASK, 32'h0000_0000);
      irq_is(1'b0);
      wr(`CLM_OFF_MASK, 32'h0000_0001);
      irq_is(1'b1);
      wr(`CLM_OFF_STAT, 32'h0000_0001);
      irq_is(1'b0);
      $display("test interrupt done");
      wr(`CLM_OFF_CTRL, 32'h0000_0004);
      wr(`CLM_OFF_STAT, 32'h0000_03FF);
      lead_req[0] <= 1'b1;
      lead_req[6] <= 1'b1;
      cyc(IVL + 50);
      rchk("stat off", `CLM_OFF_STAT, ALL, 32'h0000_0000);
      rchk("poll", `CLM_OFF_POLL, 32'h0000_00FF, 32'h0000_0001);
      rchk("poll again", `CLM_OFF_POLL, 32'h0000_00FF, 32'h0000_0000);
      $display("test polling done");
      wr(`CLM_OFF_CTRL, 32'h0001_0004);
      cust_data <= 64'h0000_0000_0000_7F00;
      cust_valid <= 8'h03;
      pkt_is(16'h7F80);
      lead_req[0] <= 1'b0;
      pkt_is(16'h7F00);
      lead_req[0] <= 1'b1;
      wr(`CLM_OFF_RATE, 32'h0000_0000);
      pkt_is(16'h7F00);
      wr(`CLM_OFF_RATE, 32'h0000_00C1);
      rchk("rate kept", `CLM_OFF_RATE, ALL, 32'h0000_0000);
      wr(`CLM_OFF_RATE, 32'h0000_00C0);
      pkt_is(16'h7F80);
      $display("test fast lead done");
      complete_run();
   end
endmodule : clm_lead_mon_test

// ===== dv/clm_port_model.sv
// Serial port equipment facing the card: leads, receive line, clock.
// Assumes the bench tells it which lead levels to present.
`timescale 1ns/1ns
module clm_port_model (
   // Clock.
   input wire logic clk_sys,
   // Lead levels asked for by the bench.
   input wire logic [39:0] lead_req,
   // Pins towards the card.
   output logic [39:0] lead_pin,
   output logic [7:0] rx_pin,
   output logic [7:0] ext_clk_pin
);
   logic [3:0] div = 4'h0;
   // Pins start quiet, with a fixed pattern on the receive lines.
   initial begin
      lead_pin = 40'h00_0000_0000;
      rx_pin = 8'h55;
      ext_clk_pin = 8'h00;
   end
   // Leads follow requests; line and clock turn every sixteen cycles,
   // slow enough to pass the card's three-stage agreement filter.
   always @(posedge clk_sys) begin
      div <= div + 4'h1;
      lead_pin <= lead_req;
      if (div == 4'hF) begin
         rx_pin <= ~rx_pin;
         ext_clk_pin <= ~ext_clk_pin;
      end
   end
endmodule : clm_port_model
